/* File: core/absm_pkg.sv */
// package of constants and types for the asynchronous bus master strobe block
package absm_pkg;
   // ***********************************************
   // widths and reset values
   // ***********************************************
   localparam int unsigned ABSM_ADDR_W = 32;
   localparam int unsigned ABSM_DATA_W = 32;
   localparam int unsigned ABSM_IRQ_W = 16;
   localparam logic ABSM_STROBE_IDLE = 1'b1;
   localparam logic ABSM_DIR_READ = 1'b1;
   localparam logic ABSM_DIR_WRITE = 1'b0;
   // cycles counted in the wait state before the cycle may end
   localparam int unsigned ABSM_MIN_LOW_CYC = 2;
   localparam logic [1:0] ABSM_MIN_LOW = 2'h2;

   // ***********************************************
   // master state machine, gray coded along the path from IDLE to END, not on the return to IDLE
   // ***********************************************
   typedef enum logic [2:0] {
      ABSM_IDLE = 3'h0,
      ABSM_ASK = 3'h1,
      ABSM_OWN = 3'h3,
      ABSM_STRB = 3'h2,
      ABSM_WAIT = 3'h6,
      ABSM_END = 3'h7
   } absm_state_e;
endpackage : absm_pkg

/* File: core/absm_sync_if.sv */
// interface carrying synchronised arbitration pins to the master core
`timescale 1ns/1ps
interface absm_sync_if;
   logic grant_n;
   logic strobe_n;
   logic ack_n;
   logic slave_low_n;
   logic slave_high_n;
   modport src (output grant_n, strobe_n, ack_n, slave_low_n, slave_high_n);
   modport dst (input grant_n, strobe_n, ack_n, slave_low_n, slave_high_n);
endinterface : absm_sync_if

/* File: core/absm_sync.sv */
// two flop synchronisers for the bus pins read by the master
`timescale 1ns/1ps
module absm_sync
   import absm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // raw pins
   input wire logic [4:0] pins_i,
   // synchronised values
   absm_sync_if.src sync
);
   logic [4:0] meta_q;
   logic [4:0] stab_q;
   // ***********************************************
   // two flops per pin, released lines read high
   // ***********************************************
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               meta_q[g] <= 1'b1;
               stab_q[g] <= 1'b1;
            end else begin
               meta_q[g] <= pins_i[g];
               stab_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate
   // map to named lines
   assign sync.grant_n = stab_q[0];
   assign sync.strobe_n = stab_q[1];
   assign sync.ack_n = stab_q[2];
   assign sync.slave_low_n = stab_q[3];
   assign sync.slave_high_n = stab_q[4];
endmodule : absm_sync

/* File: core/absm_master.sv */
// strobe based bus master: arbitration, strobe, direction and interrupt pins
// Operation
// [RULE1] with style select high, strobe falls when address and status are valid
// [RULE2] strobe returns high to end each mastered memory cycle
// [RULE3] direction high through reads, low through writes while owning bus
// [RULE4] interrupt asserted while any enabled status bit is pending
// [RULE5] masked pending bits never assert the interrupt
// [RULE6] bus request driven low while trying to gain the bus
// [RULE7] bus request released, not driven high, when not requesting
// [RULE8] grant ack only after grant, strobe, ack and slave acks are released
// [RULE9] arbiter drives grant low to offer possible mastership
// [RULE10] interrupt drops once no enabled source remains pending
`timescale 1ns/1ps
module absm_master
   import absm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // mode strap
   input wire logic bus_style_select_i,
   // transfer request from the dma engine
   input wire logic xfer_req_i,
   input wire logic xfer_read_i,
   input wire logic [ABSM_ADDR_W-1:0] xfer_addr_i,
   input wire logic [ABSM_DATA_W-1:0] xfer_wdata_i,
   output logic xfer_done_o,
   output logic [ABSM_DATA_W-1:0] xfer_rdata_o,
   // interrupt sources
   input wire logic [ABSM_IRQ_W-1:0] irq_status_i,
   input wire logic [ABSM_IRQ_W-1:0] irq_mask_i,
   // arbitration pins
   input wire logic bus_grant_in_n_i,
   input wire logic grant_ack_in_n_i,
   output logic grant_ack_out_n_o,
   output logic grant_ack_out_oe_o,
   output logic bus_ask_out_n_o,
   output logic bus_ask_out_oe_o,
   // cycle pins
   input wire logic addr_valid_strobe_in_n_i,
   output logic addr_valid_strobe_n_o,
   output logic addr_valid_strobe_oe_o,
   output logic mem_dir_line_o,
   output logic mem_dir_line_oe_o,
   output logic [ABSM_ADDR_W-1:0] addr_o,
   output logic [ABSM_DATA_W-1:0] wdata_o,
   output logic data_oe_o,
   input wire logic [ABSM_DATA_W-1:0] rdata_i,
   input wire logic slave_ack_low_n_i,
   input wire logic slave_ack_high_n_i,
   // interrupt pin, open drain
   output logic irq_n_o,
   output logic irq_oe_o
);
   absm_sync_if sy ();
   absm_state_e state_q;
   logic [1:0] low_cnt_q;
   logic bus_free;
   logic slave_acked;
   logic wait_over;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   absm_sync u_sync (
      .clk_i (clk_i),
      .srst_i (srst_i),
      .pins_i ({slave_ack_high_n_i, slave_ack_low_n_i, grant_ack_in_n_i,
                addr_valid_strobe_in_n_i, bus_grant_in_n_i}),
      .sync (sy.src)
   );

   // bus released by previous master and slave
   assign bus_free = !sy.grant_n && sy.strobe_n && sy.ack_n &&
                     sy.slave_low_n && sy.slave_high_n; // see [RULE8] [RULE9]
   assign slave_acked = !sy.slave_low_n || !sy.slave_high_n;
   // slave answered and strobe held low long enough
   assign wait_over = state_q == ABSM_WAIT && slave_acked && low_cnt_q >= ABSM_MIN_LOW;

   // ***********************************************
   // master sequencing
   // ***********************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= ABSM_IDLE;
      end else begin
         case (state_q)
            ABSM_IDLE: begin
               if (xfer_req_i && bus_style_select_i) begin
                  state_q <= ABSM_ASK;
               end
            end
            ABSM_ASK: begin
               if (bus_free) begin
                  state_q <= ABSM_OWN; // see [RULE8]
               end
            end
            ABSM_OWN: state_q <= ABSM_STRB;
            ABSM_STRB: state_q <= ABSM_WAIT;
            ABSM_WAIT: begin
               if (wait_over) begin
                  state_q <= ABSM_END;
               end
            end
            ABSM_END: state_q <= ABSM_IDLE;
            default: state_q <= ABSM_IDLE;
         endcase
      end
   end

   // strobe low time counter
   always_ff @(posedge clk_i) begin
      if (srst_i || state_q != ABSM_WAIT) begin
         low_cnt_q <= 2'h0;
      end else if (low_cnt_q != ABSM_MIN_LOW) begin
         low_cnt_q <= low_cnt_q + 2'h1;
      end
   end

   // ***********************************************
   // arbitration outputs
   // ***********************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus_ask_out_n_o <= 1'b1;
         bus_ask_out_oe_o <= 1'b0;
         grant_ack_out_n_o <= 1'b1;
         grant_ack_out_oe_o <= 1'b0;
      end else begin
         // request driven low only while asking, else released
         bus_ask_out_n_o <= 1'b0; // see [RULE7]
         bus_ask_out_oe_o <= (state_q == ABSM_IDLE && xfer_req_i &&
                              bus_style_select_i) ||
                             (state_q == ABSM_ASK && !bus_free); // see [RULE6] [RULE7]
         grant_ack_out_n_o <= 1'b0;
         grant_ack_out_oe_o <= (state_q == ABSM_ASK && bus_free) ||
                               (state_q != ABSM_IDLE && state_q != ABSM_ASK &&
                                state_q != ABSM_END); // see [RULE8]
      end
   end

   // ***********************************************
   // cycle outputs
   // ***********************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         addr_valid_strobe_n_o <= ABSM_STROBE_IDLE;
         addr_valid_strobe_oe_o <= 1'b0;
         mem_dir_line_o <= ABSM_DIR_READ;
         mem_dir_line_oe_o <= 1'b0;
         addr_o <= '0;
         wdata_o <= '0;
         data_oe_o <= 1'b0;
      end else begin
         if (state_q == ABSM_ASK && bus_free) begin
            // address and direction set up one cycle before strobe falls
            addr_o <= xfer_addr_i;
            wdata_o <= xfer_wdata_i;
            mem_dir_line_o <= xfer_read_i ? ABSM_DIR_READ : ABSM_DIR_WRITE; // see [RULE3]
         end
         addr_valid_strobe_oe_o <= grant_ack_out_oe_o;
         mem_dir_line_oe_o <= grant_ack_out_oe_o; // see [RULE3]
         data_oe_o <= grant_ack_out_oe_o && mem_dir_line_o == ABSM_DIR_WRITE;
         if (state_q == ABSM_OWN) begin
            addr_valid_strobe_n_o <= 1'b0; // see [RULE1]
         end else if (state_q == ABSM_END || state_q == ABSM_IDLE) begin
            addr_valid_strobe_n_o <= ABSM_STROBE_IDLE; // see [RULE2]
         end
      end
   end

   // read data capture and completion pulse, both standing during the end state
   // so a requester dropping its level request on done leaves idle untouched
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         xfer_done_o <= 1'b0;
         xfer_rdata_o <= '0;
      end else begin
         xfer_done_o <= wait_over;
         if (wait_over) begin
            xfer_rdata_o <= rdata_i;
         end
      end
   end

   // ***********************************************
   // interrupt pin, open drain
   // ***********************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_n_o <= 1'b1;
         irq_oe_o <= 1'b0;
      end else begin
         irq_n_o <= 1'b0;
         irq_oe_o <= |(irq_status_i & irq_mask_i); // see [RULE4] [RULE5] [RULE10]
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_strobe_fall;
      $fell(addr_valid_strobe_n_o);
   endsequence
   sequence s_strobe_rise;
      $rose(addr_valid_strobe_n_o);
   endsequence

   property p_strobe_needs_mode;
      @(posedge clk_i) disable iff (srst_i)
      s_strobe_fall |-> $past(state_q) == ABSM_OWN && addr_valid_strobe_oe_o;
   endproperty
   a_strobe_needs_mode: assert property (p_strobe_needs_mode) // see [RULE1]
      else $error("strobe fell outside owned cycle");

   property p_strobe_ends;
      @(posedge clk_i) disable iff (srst_i)
      s_strobe_fall ##1 (!addr_valid_strobe_n_o)[*2] |-> ##[0:1000] s_strobe_rise;
   endproperty
   a_strobe_ends: assert property (p_strobe_ends) // see [RULE2]
      else $error("strobe never returned high");

   property p_dir_stable;
      @(posedge clk_i) disable iff (srst_i)
      !addr_valid_strobe_n_o && !$past(addr_valid_strobe_n_o) |-> $stable(mem_dir_line_o);
   endproperty
   a_dir_stable: assert property (p_dir_stable) // see [RULE3]
      else $error("direction changed inside cycle");

   property p_irq_on;
      @(posedge clk_i) disable iff (srst_i)
      |(irq_status_i & irq_mask_i) |=> irq_oe_o;
   endproperty
   a_irq_on: assert property (p_irq_on) // see [RULE4]
      else $error("interrupt not asserted");

   property p_irq_masked;
      @(posedge clk_i) disable iff (srst_i)
      !(|(irq_status_i & irq_mask_i)) |=> !irq_oe_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked) // see [RULE5] [RULE10]
      else $error("masked interrupt asserted");

   property p_ask_low;
      @(posedge clk_i) disable iff (srst_i)
      state_q == ABSM_ASK && !bus_free |=> bus_ask_out_oe_o && !bus_ask_out_n_o;
   endproperty
   a_ask_low: assert property (p_ask_low) // see [RULE6]
      else $error("request not driven while asking");

   property p_ask_release;
      @(posedge clk_i) disable iff (srst_i)
      state_q != ABSM_IDLE && state_q != ABSM_ASK |=> !bus_ask_out_oe_o;
   endproperty
   a_ask_release: assert property (p_ask_release) // see [RULE7]
      else $error("request driven while not asking");

   property p_ack_cond;
      @(posedge clk_i) disable iff (srst_i)
      $rose(grant_ack_out_oe_o) |-> $past(bus_free);
   endproperty
   a_ack_cond: assert property (p_ack_cond) // see [RULE8]
      else $error("grant ack without free bus");
endmodule : absm_master

/* File: test/absm_far_model.sv */
// far side model: bus arbiter and a memory slave with wait states
`timescale 1ns/1ps
module absm_far_model
   import absm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // resolved pins from the master
   input wire logic ask_n_i,
   input wire logic strobe_n_i,
   // bench controls
   input wire logic slow_i,
   input wire logic busy_i,
   input wire logic [ABSM_DATA_W-1:0] rd_word_i,
   // answers
   output logic grant_n_o,
   output logic slave_low_n_o,
   output logic slave_high_n_o,
   output logic [ABSM_DATA_W-1:0] rdata_o
);
   logic [3:0] wait_q;
   logic ack_q;
   // grant offered one cycle after a low request is seen
   always_ff @(posedge clk_i) begin
      if (srst_i) grant_n_o <= 1'b1;
      else grant_n_o <= ask_n_i;
   end
   // slave answers after a short or long wait, releases with the strobe
   always_ff @(posedge clk_i) begin
      if (srst_i || strobe_n_i) begin
         wait_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (wait_q == (slow_i ? 4'h6 : 4'h1)) ack_q <= 1'b1;
      else wait_q <= wait_q + 4'h1;
   end
   // busy stands for a previous slave still holding its acks
   assign slave_low_n_o = ~(ack_q | busy_i);
   assign slave_high_n_o = ~(ack_q | busy_i);
   // released data lines show the inverted word, never the stale one
   assign rdata_o = ack_q ? rd_word_i : ~rd_word_i;
endmodule : absm_far_model

/* File: test/testbench.sv */
// self-checking bench for the strobe based bus master
`timescale 1ns/1ps
module testbench
   import absm_pkg::*;
;
   logic clk_i = 1'b0, srst_i = 1'b1, bus_style_select_i = 1'b1, xfer_req_i = 1'b0;
   logic xfer_read_i = 1'b1, slow = 1'b0, busy = 1'b0;
   logic [31:0] xfer_addr_i = 32'h0, xfer_wdata_i = 32'h0, rd_word = 32'hA5C3_0F1E;
   logic [15:0] irq_status_i = 16'h0, irq_mask_i = 16'h0;
   logic xfer_done_o, grant_ack_out_n_o, grant_ack_out_oe_o, bus_ask_out_n_o, bus_ask_out_oe_o;
   logic addr_valid_strobe_n_o, addr_valid_strobe_oe_o, mem_dir_line_o, mem_dir_line_oe_o;
   logic data_oe_o, irq_n_o, irq_oe_o, grant_n, sl_n, sh_n;
   logic [31:0] xfer_rdata_o, addr_o, wdata_o, rdata;
   int n_mismatch = 0, checks = 0;
   // open drain and released pins pulled up
   wire ask_w = bus_ask_out_oe_o ? bus_ask_out_n_o : 1'b1;
   wire strb_w = addr_valid_strobe_oe_o ? addr_valid_strobe_n_o : 1'b1;
   wire gack_w = grant_ack_out_oe_o ? grant_ack_out_n_o : 1'b1;

   absm_master DUT (.clk_i, .srst_i, .bus_style_select_i, .xfer_req_i, .xfer_read_i,
      .xfer_addr_i, .xfer_wdata_i, .xfer_done_o, .xfer_rdata_o, .irq_status_i, .irq_mask_i,
      .bus_grant_in_n_i(grant_n), .grant_ack_in_n_i(gack_w), .grant_ack_out_n_o,
      .grant_ack_out_oe_o, .bus_ask_out_n_o, .bus_ask_out_oe_o,
      .addr_valid_strobe_in_n_i(strb_w), .addr_valid_strobe_n_o, .addr_valid_strobe_oe_o,
      .mem_dir_line_o, .mem_dir_line_oe_o, .addr_o, .wdata_o, .data_oe_o, .rdata_i(rdata),
      .slave_ack_low_n_i(sl_n), .slave_ack_high_n_i(sh_n), .irq_n_o, .irq_oe_o);
   absm_far_model far (.clk_i, .srst_i, .ask_n_i(ask_w), .strobe_n_i(strb_w), .slow_i(slow),
      .busy_i(busy), .rd_word_i(rd_word), .grant_n_o(grant_n), .slave_low_n_o(sl_n),
      .slave_high_n_o(sh_n), .rdata_o(rdata));

   // clock
   initial forever #5 clk_i = ~clk_i;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      if (n_mismatch == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim

   // one mastered transfer, judged cycle by cycle
   task automatic xfer(input logic rd, input logic [31:0] a, input logic [31:0] wd,
                       input logic slw);
      int n;
      logic ask, fell;
      n = 0;
      ask = 1'b0;
      fell = 1'b0;
      @(posedge clk_i);
      slow <= slw;
      xfer_req_i <= 1'b1;
      xfer_read_i <= rd;
      xfer_addr_i <= a;
      xfer_wdata_i <= wd;
      do begin
         @(negedge clk_i);
         n++;
         if (bus_ask_out_oe_o === 1'b1 && bus_ask_out_n_o === 1'b0) ask = 1'b1;
         if (strb_w === 1'b0) begin
            fell = 1'b1;
            chk(mem_dir_line_o, rd, "direction");
            chk(mem_dir_line_oe_o, 1'b1, "direction driven");
            chk(data_oe_o, !rd, "data drive");
            chk(gack_w, 1'b0, "grant ack held");
            chk(addr_o, a, "address");
            if (!rd) chk(wdata_o, wd, "write data");
         end
      end while (xfer_done_o !== 1'b1 && n < 200);
      chk(xfer_done_o, 1'b1, "done");
      chk(ask, 1'b1, "request low");
      chk(fell, 1'b1, "strobe fell");
      if (rd) chk(xfer_rdata_o, rd_word, "read data");
      // request held through the edge that samples done high
      @(posedge clk_i);
      xfer_req_i <= 1'b0;
      @(negedge clk_i);
      chk(addr_valid_strobe_n_o, 1'b1, "strobe ends high");
      chk(addr_valid_strobe_oe_o, 1'b1, "strobe driven high");
      chk(bus_ask_out_oe_o, 1'b0, "request released");
      chk(xfer_done_o, 1'b0, "done one cycle");
   endtask : xfer

   // requests are ignored with style select low
   task automatic refused;
      @(posedge clk_i);
      bus_style_select_i <= 1'b0;
      xfer_req_i <= 1'b1;
      repeat (20) begin
         @(negedge clk_i);
         chk(bus_ask_out_oe_o | addr_valid_strobe_oe_o, 1'b0, "mode off");
      end
      @(posedge clk_i);
      xfer_req_i <= 1'b0;
      @(posedge clk_i);
      bus_style_select_i <= 1'b1;
   endtask : refused

   // no grant ack while a previous slave still holds its acks
   task automatic held_off;
      @(posedge clk_i);
      busy <= 1'b1;
      xfer_req_i <= 1'b1;
      xfer_read_i <= 1'b1;
      xfer_addr_i <= 32'h0000_0040;
      repeat (20) begin
         @(negedge clk_i);
         chk(grant_ack_out_oe_o, 1'b0, "ack held off");
      end
      chk(ask_w, 1'b0, "still asking");
      @(posedge clk_i);
      busy <= 1'b0;
      xfer(1'b1, 32'h0000_0040, 32'h0, 1'b0);
   endtask : held_off

   // interrupt follows enabled pending sources only
   task automatic irq_cases;
      logic [32:0] tbl [4] = '{{16'h0005, 16'h0004, 1'b1}, {16'h0005, 16'h000A, 1'b0},
                               {16'h8000, 16'h8000, 1'b1}, {16'h0000, 16'hFFFF, 1'b0}};
      foreach (tbl[i]) begin
         @(posedge clk_i);
         irq_status_i <= tbl[i][32:17];
         irq_mask_i <= tbl[i][16:1];
         repeat (3) @(negedge clk_i);
         chk(irq_oe_o, tbl[i][0], "interrupt");
         if (tbl[i][0]) chk(irq_n_o, 1'b0, "interrupt low");
      end
   endtask : irq_cases

   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      xfer(1'b1, 32'h1234_5678, 32'h0, 1'b0);
      xfer(1'b0, 32'h0000_0FFC, 32'hDEAD_BEEF, 1'b1);
      xfer(1'b1, 32'hFFFF_FFFC, 32'h0, 1'b1);
      refused();
      held_off();
      irq_cases();
      end_sim();
   end

   // watchdog
   initial begin
      #100us;
      n_mismatch++;
      end_sim();
   end
endmodule : testbench
